// >>> src/conv_timing_regs.svh
// Operation
// (R01) Any software write to the timing control register ends the running conversion sequence and does not start a new one.
// (R02) Bit 7 selects result width: clear gives 10-bit results, set gives 8-bit results with a shorter conversion.
// (R03) Bits 6-5 select how many conversion clock cycles the second sampling phase lasts.
// (R04) Second-phase codes 00, 01, 10, 11 give 2, 4, 8 and 16 conversion clock periods.
// (R05) Every sample starts with a fixed two-cycle first phase that moves the buffered input onto the storage node.
// (R06) After the first phase the external input is tied straight to the storage node for the selected duration.
// (R07) Bits 4-0 set the conversion clock to bus clock / (value + 1) / 2, at most half the bus clock.
// (R08) After reset the prescale field holds 5, giving bus clock / 12.
// (R09) The conversion clock is an enable pulse from a reloading bus-clock counter, and phases count those pulses.
`ifndef CONV_TIMING_REGS_SVH
`define CONV_TIMING_REGS_SVH

`define CTC_ADDR_W        4
`define CTC_OFFSET        4'h4
`define CTC_STATUS_OFFSET 4'h5
`define CTC_WIDTH_BIT     7
`define CTC_SMP_HI        6
`define CTC_SMP_LO        5
`define CTC_PRS_HI        4
`define CTC_PRS_LO        0
`define CTC_RESET         8'h05
`define CTC_FIRST_PHASE   5'h02
`define CTC_SMP_LEN0      5'h02
`define CTC_SMP_LEN1      5'h04
`define CTC_SMP_LEN2      5'h08
`define CTC_SMP_LEN3      5'h10
`define CTC_CONV_BITS10   5'h0A
`define CTC_CONV_BITS8    5'h08

`endif

// >>> src/conv_timing_pkg.sv
package conv_timing_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_PHASE1 = 3'b001,
    ST_PHASE2 = 3'b010,
    ST_CONV   = 3'b011
  } seq_state_t;

  typedef logic [4:0] cyc_count_t;

endpackage : conv_timing_pkg

// >>> src/conv_clock_div.sv
`timescale 1ns/1ps
`include "conv_timing_regs.svh"

// conversion clock enable: one pulse every 2*(prescale+1) bus clocks
module conv_clock_div #(
  parameter int PRS_W = 5
) (
  input  wire logic             mclk,     // bus clock
  input  wire logic             srst,     // synchronous reset
  input  wire logic             restart,  // realign divider
  input  wire logic [PRS_W-1:0] prescale, // prescale field
  output logic                  tick      // conversion clock enable
);

  initial begin
    if (PRS_W < 1 || PRS_W > 16) $error("conv_clock_div: bad PRS_W");
  end

  logic [PRS_W:0] cnt_r;
  logic [PRS_W:0] reload;

  // half period is prescale+1, full period twice that
  assign reload = {prescale, 1'b1}; // (R07)

  // reloading down-counter, tick on zero
  always_ff @(posedge mclk) begin
    if (srst || restart) begin
      cnt_r <= reload;
      tick  <= 1'b0;
    end else if (cnt_r == '0) begin
      cnt_r <= reload; // (R09)
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r - 1'b1;
      tick  <= 1'b0;
    end
  end

  property p_tick_spacing;
    @(posedge mclk) disable iff (srst || restart) tick |=> !tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick not single cycle"); // (R07)

endmodule : conv_clock_div

// >>> src/conv_phase_counter.sv
`timescale 1ns/1ps

// counts conversion clock enables down to zero, flags completion
module conv_phase_counter #(
  parameter int CNT_W = 5
) (
  input  wire logic             mclk,  // bus clock
  input  wire logic             srst,  // synchronous reset
  input  wire logic             load,  // load new length
  input  wire logic [CNT_W-1:0] len,   // length in conv clocks
  input  wire logic             tick,  // conversion clock enable
  output logic                  done   // last tick of the phase
);

  initial begin
    if (CNT_W < 2) $error("conv_phase_counter: bad CNT_W");
  end

  logic [CNT_W-1:0] left_r;

  assign done = tick && (left_r == {{(CNT_W-1){1'b0}}, 1'b1});

  // loaded value counts down once per conversion clock
  always_ff @(posedge mclk) begin
    if (srst) begin
      left_r <= '0;
    end else if (load) begin
      left_r <= len;
    end else if (tick && left_r != '0) begin
      left_r <= left_r - 1'b1; // (R09)
    end
  end

endmodule : conv_phase_counter

// >>> src/conv_timing_ctrl.sv
`timescale 1ns/1ps
`include "conv_timing_regs.svh"

// conversion timing control: register, conversion clock and sample sequencer
module conv_timing_ctrl
  import conv_timing_pkg::*;
#(
  parameter int ADDR_W = `CTC_ADDR_W
) (
  input  wire logic              mclk,        // bus clock, 100 MHz
  input  wire logic              srst,        // synchronous reset, high
  input  wire logic [ADDR_W-1:0] addr,        // register address
  input  wire logic [7:0]        wrData,      // write data
  input  wire logic              wrStb,       // write strobe
  input  wire logic              rdStb,       // read strobe
  output logic [7:0]             rdData,      // read data, cycle after rdStb
  input  wire logic              startSeq,    // core asks for a sequence
  output logic                   convTick,    // conversion clock enable
  output logic                   bufSample,   // first phase: buffer to node
  output logic                   directSample,// second phase: input to node
  output logic                   converting,  // conversion running
  output logic                   seqDone,     // one-cycle pulse, sample+convert done
  output logic                   seqAbort,    // one-cycle pulse, sequence aborted
  output logic                   resultWidth8 // 1: 8-bit results
);

  initial begin
    if (ADDR_W < 3) $error("conv_timing_ctrl: ADDR_W too small");
  end

  // phase length decode, used for second phase
  function automatic cyc_count_t smpLen(input logic [1:0] code);
    unique case (code)
      2'b00: smpLen = `CTC_SMP_LEN0; // (R04)
      2'b01: smpLen = `CTC_SMP_LEN1;
      2'b10: smpLen = `CTC_SMP_LEN2;
      2'b11: smpLen = `CTC_SMP_LEN3;
    endcase
  endfunction : smpLen

  logic [7:0]  ctl_r;
  seq_state_t  state_r;
  logic        ctlWrite;
  logic        statWrite;
  logic        phaseDone;
  logic        phaseLoad;
  cyc_count_t  phaseLen;
  logic [1:0]  sampleSel;
  logic [4:0]  prescale;

  assign ctlWrite  = wrStb && (addr == ADDR_W'(`CTC_OFFSET));
  assign statWrite = wrStb && (addr == ADDR_W'(`CTC_STATUS_OFFSET));
  assign sampleSel = ctl_r[`CTC_SMP_HI:`CTC_SMP_LO]; // (R03)
  assign prescale  = ctl_r[`CTC_PRS_HI:`CTC_PRS_LO];
  assign resultWidth8 = ctl_r[`CTC_WIDTH_BIT]; // (R02)

  // control register; reset value gives bus clock / 12
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctl_r <= `CTC_RESET; // (R08)
    end else if (ctlWrite) begin
      ctl_r <= wrData;
    end
  end

  // read mux; status word shows sequencer state, unmapped reads zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdData <= 8'h00;
    end else if (rdStb) begin
      if (addr == ADDR_W'(`CTC_OFFSET)) begin
        rdData <= ctl_r;
      end else if (addr == ADDR_W'(`CTC_STATUS_OFFSET)) begin
        rdData <= {5'h00, state_r};
      end else begin
        rdData <= 8'h00;
      end
    end else begin
      rdData <= 8'h00;
    end
  end

  // divider is realigned on a write; its first period still uses the old prescale, the new rate applies after it
  conv_clock_div #(.PRS_W(5)) u_div (
    .mclk     (mclk),
    .srst     (srst),
    .restart  (ctlWrite),
    .prescale (prescale),
    .tick     (convTick)
  );

  // phase length chosen from the state being entered
  always_comb begin
    phaseLoad = 1'b0;
    phaseLen  = `CTC_FIRST_PHASE;
    unique case (state_r)
      ST_IDLE: begin
        phaseLoad = startSeq && !ctlWrite;
        phaseLen  = `CTC_FIRST_PHASE; // (R05)
      end
      ST_PHASE1: begin
        phaseLoad = phaseDone;
        phaseLen  = smpLen(sampleSel); // (R06)
      end
      ST_PHASE2: begin
        phaseLoad = phaseDone;
        phaseLen  = resultWidth8 ? `CTC_CONV_BITS8 : `CTC_CONV_BITS10; // (R02)
      end
      ST_CONV: begin
        phaseLoad = 1'b0;
        phaseLen  = `CTC_FIRST_PHASE;
      end
      default: begin
        phaseLoad = 1'b0;
        phaseLen  = `CTC_FIRST_PHASE;
      end
    endcase
  end

  conv_phase_counter #(.CNT_W(5)) u_cnt (
    .mclk (mclk),
    .srst (srst),
    .load (phaseLoad),
    .len  (phaseLen),
    .tick (convTick),
    .done (phaseDone)
  );

  // sequencer; a control register write ends any sequence and never starts one
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= ST_IDLE;
    end else if (ctlWrite) begin
      state_r <= ST_IDLE; // (R01)
    end else begin
      unique case (state_r)
        ST_IDLE:   if (startSeq) state_r <= ST_PHASE1;
        ST_PHASE1: if (phaseDone) state_r <= ST_PHASE2; // (R05)
        ST_PHASE2: if (phaseDone) state_r <= ST_CONV; // (R06)
        ST_CONV:   if (phaseDone) state_r <= ST_IDLE;
        default:   state_r <= ST_IDLE;
      endcase
    end
  end

  // event pulses, registered
  always_ff @(posedge mclk) begin
    if (srst) begin
      seqDone  <= 1'b0;
      seqAbort <= 1'b0;
    end else begin
      seqDone  <= !ctlWrite && state_r == ST_CONV && phaseDone;
      seqAbort <= ctlWrite && state_r != ST_IDLE; // (R01)
    end
  end

  assign bufSample    = (state_r == ST_PHASE1);
  assign directSample = (state_r == ST_PHASE2);
  assign converting   = (state_r == ST_CONV);

  // helper: count ticks spent in each phase of a sequence, conversion included
  logic [5:0] tickCnt_r;
  always_ff @(posedge mclk) begin
    if (srst || phaseLoad || ctlWrite) begin
      tickCnt_r <= 6'h00;
    end else if (convTick && state_r != ST_IDLE) begin
      tickCnt_r <= tickCnt_r + 6'h01;
    end
  end

  // helper: bus clocks since the last enable; only a period with no write in it is judged
  logic [6:0] tickGap_r;
  logic       gapValid_r;
  always_ff @(posedge mclk) begin
    if (srst || ctlWrite) begin
      tickGap_r  <= 7'h00;
      gapValid_r <= 1'b0;
    end else if (convTick) begin
      tickGap_r  <= 7'h01;
      gapValid_r <= 1'b1;
    end else begin
      tickGap_r  <= tickGap_r + 7'h01;
    end
  end

  property p_write_aborts;
    @(posedge mclk) disable iff (srst) ctlWrite |=> state_r == ST_IDLE;
  endproperty
  a_write_aborts: assert property (p_write_aborts) else $error("write did not abort"); // (R01)

  property p_write_no_start;
    @(posedge mclk) disable iff (srst) ctlWrite && state_r == ST_IDLE |=> !bufSample;
  endproperty
  a_write_no_start: assert property (p_write_no_start) else $error("write started seq"); // (R01)

  property p_width_out;
    @(posedge mclk) disable iff (srst) ctlWrite |=> resultWidth8 == $past(wrData[7]);
  endproperty
  a_width_out: assert property (p_width_out) else $error("width select wrong"); // (R02)

  sequence s_phase1_end;
    state_r == ST_PHASE1 && phaseDone && !ctlWrite;
  endsequence

  property p_phase1_len;
    @(posedge mclk) disable iff (srst) s_phase1_end |-> tickCnt_r == 6'h01;
  endproperty
  a_phase1_len: assert property (p_phase1_len) else $error("first phase not 2"); // (R05)

  property p_phase2_len;
    @(posedge mclk) disable iff (srst)
      state_r == ST_PHASE2 && phaseDone && !ctlWrite
      |-> tickCnt_r == 6'(smpLen(sampleSel)) - 6'h01;
  endproperty
  a_phase2_len: assert property (p_phase2_len) else $error("second phase length"); // (R04)

  property p_phase_order;
    @(posedge mclk) disable iff (srst) s_phase1_end |=> directSample;
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("phase order"); // (R06)

  property p_sel_field;
    @(posedge mclk) disable iff (srst) ctlWrite |=> sampleSel == $past(wrData[6:5]);
  endproperty
  a_sel_field: assert property (p_sel_field) else $error("sample select"); // (R03)

  property p_reset_prs;
    @(posedge mclk) srst |=> prescale == 5'h05;
  endproperty
  a_reset_prs: assert property (p_reset_prs) else $error("reset prescale"); // (R08)

  property p_tick_period;
    @(posedge mclk) disable iff (srst || ctlWrite)
      convTick && prescale == 5'h00 ##1 !ctlWrite |=> convTick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("div by 2 wrong"); // (R07)

  // sequencer checks: start, abort pulse, conversion length, completion pulse
  sequence s_conv_end;
    state_r == ST_CONV && phaseDone && !ctlWrite;
  endsequence

  property p_seq_start;
    @(posedge mclk) disable iff (srst)
      state_r == ST_IDLE && startSeq && !ctlWrite |=> bufSample;
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("sequence did not start"); // (R05)

  property p_abort_pulse;
    @(posedge mclk) disable iff (srst) ctlWrite && state_r != ST_IDLE |=> seqAbort;
  endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort pulse missing"); // (R01)

  property p_idle_wr;
    @(posedge mclk) disable iff (srst) ctlWrite && state_r == ST_IDLE |=> !seqAbort;
  endproperty
  a_idle_wr: assert property (p_idle_wr) else $error("abort while idle"); // (R01)

  property p_conv_len;
    @(posedge mclk) disable iff (srst)
      s_conv_end |-> tickCnt_r ==
        (resultWidth8 ? 6'(`CTC_CONV_BITS8) : 6'(`CTC_CONV_BITS10)) - 6'h01;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length"); // (R02)

  property p_done_pulse;
    @(posedge mclk) disable iff (srst) s_conv_end |=> seqDone && state_r == ST_IDLE;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done pulse missing"); // (R02)

  // register bus, reset and divider checks: status writes ignored, read data one cycle after the strobe, reset state, enable spacing
  property p_status_write;
    @(posedge mclk) disable iff (srst) statWrite |=> ctl_r == $past(ctl_r);
  endproperty
  a_status_write: assert property (p_status_write) else $error("status write hit control"); // (R02)

  property p_read_ctl;
    @(posedge mclk) disable iff (srst)
      rdStb && addr == ADDR_W'(`CTC_OFFSET) |=> rdData == $past(ctl_r);
  endproperty
  a_read_ctl: assert property (p_read_ctl) else $error("control readback"); // (R02)

  property p_read_status;
    @(posedge mclk) disable iff (srst)
      rdStb && addr == ADDR_W'(`CTC_STATUS_OFFSET) |=> rdData == {5'h00, $past(state_r)};
  endproperty
  a_read_status: assert property (p_read_status) else $error("status readback"); // (R01)

  property p_read_idle;
    @(posedge mclk) disable iff (srst) !rdStb |=> rdData == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data without strobe"); // (R02)

  property p_reset_idle;
    @(posedge mclk)
      srst |=> state_r == ST_IDLE && !seqDone && !seqAbort && rdData == 8'h00;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("reset state"); // (R08)

  property p_tick_gap;
    @(posedge mclk) disable iff (srst || ctlWrite)
      convTick && gapValid_r |-> tickGap_r == {1'b0, prescale, 1'b0} + 7'h02;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("enable spacing wrong"); // (R07)

endmodule : conv_timing_ctrl

// >>> verification/conv_core_model.sv
`timescale 1ns/1ps

// analog core stand-in: asks for sequences and tallies conversion clock enables per phase
module conv_core_model (
  input  wire logic       mclk,         // bus clock
  input  wire logic       srst,         // synchronous reset
  input  wire logic       kick,         // bench asks for one sequence
  input  wire logic       convTick,     // conversion clock enable
  input  wire logic       bufSample,    // first sample phase
  input  wire logic       directSample, // second sample phase
  input  wire logic       converting,   // conversion phase
  output logic            startSeq,     // one-cycle start request
  output logic [7:0]      ph1Cnt,       // ticks in first phase
  output logic [7:0]      ph2Cnt,       // ticks in second phase
  output logic [7:0]      convCnt       // ticks while converting
);
  // a one-cycle strobe, so a level-sensitive start cannot hide a double start
  always_ff @(posedge mclk) begin
    if (srst) startSeq <= 1'b0;
    else startSeq <= kick;
  end

  // a phase level still stands at its last tick edge, so that tick counts for it
  always_ff @(posedge mclk) begin
    if (srst || kick) begin
      ph1Cnt  <= 8'h00;
      ph2Cnt  <= 8'h00;
      convCnt <= 8'h00;
    end else if (convTick) begin
      ph1Cnt  <= ph1Cnt + {7'h00, bufSample};
      ph2Cnt  <= ph2Cnt + {7'h00, directSample};
      convCnt <= convCnt + {7'h00, converting};
    end
  end
endmodule : conv_core_model

// >>> verification/tb_conv_timing_ctrl.sv
`timescale 1ns/1ps

module tb_conv_timing_ctrl;
  logic       mclk, srst, wrStb, rdStb, kick, startSeq, convTick, bufSample;
  logic       directSample, converting, seqDone, seqAbort, resultWidth8;
  logic [3:0] addr;
  logic [7:0] wrData, rdData, got, c1, c2, c3, anyOn;
  int         mismatches, total_checks, ctl, gap, n, prs;

  conv_timing_ctrl i_dut (.mclk(mclk), .srst(srst), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .startSeq(startSeq),
    .convTick(convTick), .bufSample(bufSample), .directSample(directSample),
    .converting(converting), .seqDone(seqDone), .seqAbort(seqAbort),
    .resultWidth8(resultWidth8));

  conv_core_model i_core (.mclk(mclk), .srst(srst), .kick(kick), .convTick(convTick),
    .bufSample(bufSample), .directSample(directSample), .converting(converting),
    .startSeq(startSeq), .ph1Cnt(c1), .ph2Cnt(c2), .convCnt(c3));

  // clock at 100 MHz
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // one-cycle write; the model register follows only the control address
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a; wrData <= d; wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
    if (a == 4'h4) ctl = d;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    addr <= a; rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    @(negedge mclk);
    got = rdData;
  endtask : rd

  // spacing of two enables; only the stretch from a write to the first enable still runs at the old prescale
  task automatic tickGap;
    for (int i = 0; i < 200 && convTick !== 1'b1; i++) @(negedge mclk);
    @(negedge mclk);
    for (gap = 1; gap < 200 && convTick !== 1'b1; gap++) @(negedge mclk);
  endtask : tickGap

  task automatic startIt;
    @(posedge mclk);
    kick <= 1'b1;
    @(posedge mclk);
    kick <= 1'b0;
  endtask : startIt

  initial begin
    #500us;
    mismatches++;
    stop_test();
  end

  initial begin
    srst = 1'b1; wrStb = 1'b0; rdStb = 1'b0; kick = 1'b0; addr = 4'h0; wrData = 8'h00;
    void'($urandom(32'hBE84F81E));
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    ctl = 8'h05;
    // reset value, readback, unmapped and status writes ignored
    rd(4'h4); chk(got, 8'h05);
    tickGap(); tickGap(); chk(gap[7:0], 8'h0C);
    wr(4'h4, 8'($urandom)); rd(4'h4); chk(got, 8'(ctl));
    wr(4'hA, 8'h3C); wr(4'h5, 8'h03); rd(4'h4); chk(got, 8'(ctl));
    rd(4'h5); chk(got, 8'h00);
    rd(4'h9); chk(got, 8'h00);
    $display("test registers done");
    // divider rate at both ends and two random fields
    for (int k = 0; k < 4; k++) begin
      prs = (k == 0) ? 0 : (k == 1) ? 31 : $urandom_range(30, 1);
      wr(4'h4, 8'(prs)); tickGap(); tickGap();
      chk(gap[7:0], 8'(2 * (prs + 1)));
    end
    $display("test divider done");
    // every sample code with both widths, back to back
    for (int k = 0; k < 8; k++) begin
      wr(4'h4, {k[0], k[2:1], 5'($urandom_range(3))});
      startIt();
      for (n = 0; n < 3000 && seqDone !== 1'b1; n++) @(negedge mclk);
      chk({7'h00, seqDone}, 8'h01);
      chk(c1, 8'h02);
      chk(c2, 8'h02 << k[2:1]);
      chk(c3, k[0] ? 8'h08 : 8'h0A);
      chk({7'h00, resultWidth8}, {7'h00, k[0]});
    end
    $display("test sequences done");
    // write during second phase aborts and leaves the block idle
    wr(4'h4, 8'h63);
    startIt();
    for (n = 0; n < 500 && directSample !== 1'b1; n++) @(negedge mclk);
    rd(4'h5); chk(got, 8'h02);
    wr(4'h4, 8'h01);
    @(negedge mclk);
    chk({7'h00, seqAbort}, 8'h01);
    anyOn = 8'h00;
    repeat (60) begin
      anyOn = anyOn | {5'h00, bufSample, directSample, converting};
      @(negedge mclk);
    end
    chk(anyOn, 8'h00);
    rd(4'h5); chk(got, 8'h00);
    wr(4'h4, 8'h01);
    @(negedge mclk);
    chk({7'h00, seqAbort}, 8'h00);
    $display("test abort done");
    // reset in mid-sequence brings back the default rate and an idle block
    wr(4'h4, 8'hE0);
    startIt();
    for (n = 0; n < 500 && directSample !== 1'b1; n++) @(negedge mclk);
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    ctl = 8'h05;
    rd(4'h4); chk(got, 8'h05);
    rd(4'h5); chk(got, 8'h00);
    chk({7'h00, resultWidth8}, 8'h00);
    tickGap(); tickGap(); chk(gap[7:0], 8'h0C);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule : tb_conv_timing_ctrl
